// *** src/dsac_top.sv ***
// Data-space access unit: byte/word access, alignment and stack checks
//
// Summary of operation
// - Data path and registers are 16 bits; word-wide byte-addressed memory.
// - Byte read fetches the whole word; address bit 0 picks the byte.
// - Selected byte lands on the low X lane; Y path fetches words only.
// - Shared word decode, separate byte strobes; byte write touches one half.
// - Post-increment steps pointer by 1 for bytes and 2 for words.
// - Word access at an odd address raises an address error trap.
// - Misaligned read completes; misaligned write runs but skips memory.
// - Byte load writes the destination low byte only, upper byte kept.
// - Sign-extend widens a signed byte; zero-extend clears the upper byte.
// - Near region 0x0000 to 0x1FFF is reached by a 13-bit direct field.
// - Full direct mode uses a 16-bit field over the whole X space.
// - Pointer marks the free word; push post-increments, pop pre-decrements.
// - Call pushes the upper program counter word with its high byte cleared.
// - Exception entry puts the status low byte into the pushed upper byte.
// - Stack limit has no reset value; its bit 0 always reads zero.
// - Stack addresses above the limit trap; a push at the limit does not.
// - A stack address below 0x0800 raises a stack error trap.
// - Unimplemented or wrong-space addresses read back as an all-zero word.
// - Effective addresses are 16-bit byte addresses over 64 Kbytes.
`timescale 1ns/100ps
`include "dsac_map.svh"

module dsac_top import dsac_pkg::*; (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  // Access request from the execution pipeline
  input  wire dsac_req_s   REQ,
  // Data memory array
  output logic [14:0]      MEM_WADDR,
  output logic             MEM_RD,
  output logic             MEM_WE_LO,
  output logic             MEM_WE_HI,
  output logic [15:0]      MEM_WDATA,
  input  wire logic [15:0] MEM_RDATA,
  // Results back to the pipeline
  output logic             RES_VALID,
  output logic [15:0]      RES_DATA,
  output logic [15:0]      PTR_NEXT,
  output logic             ADDR_TRAP,
  output logic             STACK_TRAP,
  // Register port
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [15:0]      REG_RDATA
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic is_push(input dsac_op_e op);
    is_push = (op == DSAC_OP_PUSH) || (op == DSAC_OP_PUSH_CALL) ||
              (op == DSAC_OP_PUSH_EXC);
  endfunction : is_push

  function automatic logic is_mem(input dsac_op_e op);
    is_mem = (op != DSAC_OP_SIGN_EXT) && (op != DSAC_OP_ZERO_EXT);
  endfunction : is_mem

  function automatic logic in_y(input logic [15:0] a);
    in_y = (a >= `DSAC_Y_BASE) && (a < `DSAC_Y_END);
  endfunction : in_y

  ////////////////////////////////////////////////////////////////////////////
  // Effective address and checks

  logic [15:0] sp_ff;
  logic [15:0] limit_ff;
  logic [1:0]  stat_ff;
  dsac_stage_s s1_ff;
  dsac_stage_s s2_ff;

  logic [15:0] ea;
  logic        is_stack;
  logic        is_store;
  logic        word_acc;
  logic        misalign;
  logic        zero_rd;
  logic        stack_err;
  logic [15:0] store_data;
  logic [15:0] nxt_ptr;

  always_comb begin
    case (REQ.mode)
      DSAC_MODE_NEAR: ea = REQ.addr_field & `DSAC_NEAR_TOP;
      DSAC_MODE_FULL: ea = REQ.addr_field;
      default:        ea = REQ.pointer;
    endcase
    is_stack = is_push(REQ.op) || (REQ.op == DSAC_OP_POP);
    if (is_push(REQ.op))
      ea = sp_ff;
    else if (REQ.op == DSAC_OP_POP)
      ea = sp_ff - `DSAC_WORD_STEP;
    is_store = (REQ.op == DSAC_OP_STORE) || is_push(REQ.op);
    word_acc = !REQ.byte_op || REQ.y_fetch || is_stack;
    misalign = REQ.valid && is_mem(REQ.op) && word_acc && ea[0];
    zero_rd  = (ea >= `DSAC_IMPL_END) ||
               (REQ.y_fetch && !in_y(ea)) ||
               (REQ.mac_x && in_y(ea));
    stack_err = REQ.valid && is_stack &&
                ((ea < `DSAC_SFR_END) || (ea > limit_ff));
    case (REQ.op)
      DSAC_OP_PUSH_CALL: store_data = {`DSAC_ZERO_BYTE, REQ.wdata[7:0]};
      DSAC_OP_PUSH_EXC:
        store_data = {REQ.status_low_byte, REQ.wdata[7:0]};
      default:
        if (word_acc)
          store_data = REQ.wdata;
        else
          store_data = {REQ.wdata[7:0], REQ.wdata[7:0]};
    endcase
    nxt_ptr = REQ.pointer;
    if (REQ.mode == DSAC_MODE_POST_INC)
      nxt_ptr = REQ.pointer +
                (word_acc ? `DSAC_WORD_STEP : `DSAC_BYTE_STEP);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory request, one cycle after the pipeline request

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      MEM_WADDR <= 15'h0000;
      MEM_RD    <= 1'b0;
      MEM_WE_LO <= 1'b0;
      MEM_WE_HI <= 1'b0;
      MEM_WDATA <= `DSAC_ZERO_WORD;
    end else begin
      MEM_WADDR <= ea[15:1];
      MEM_RD    <= REQ.valid && is_mem(REQ.op) && !is_store && !zero_rd;
      // Strobes depend on the alignment test decided this same cycle
      MEM_WE_LO <= REQ.valid && is_store && !misalign && !zero_rd &&
                   (word_acc || !ea[0]);
      MEM_WE_HI <= REQ.valid && is_store && !misalign && !zero_rd &&
                   (word_acc || ea[0]);
      MEM_WDATA <= store_data;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PTR_NEXT   <= `DSAC_ZERO_WORD;
      ADDR_TRAP  <= 1'b0;
      STACK_TRAP <= 1'b0;
    end else begin
      PTR_NEXT   <= nxt_ptr;
      ADDR_TRAP  <= misalign;
      STACK_TRAP <= stack_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read pipeline: memory answers in the cycle after its strobe

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff.valid    <= REQ.valid && !is_store;
      s1_ff.op       <= REQ.op;
      s1_ff.byte_op  <= !word_acc;
      s1_ff.byte_sel <= ea[0];
      s1_ff.zero     <= zero_rd;
      s1_ff.dest_old <= REQ.dest_old;
      s2_ff          <= s1_ff;
    end
  end

  logic [15:0] rd_word;
  logic [7:0]  rd_byte;
  logic [15:0] nxt_res;

  always_comb begin
    rd_word = s2_ff.zero ? `DSAC_ZERO_WORD : MEM_RDATA;
    rd_byte = s2_ff.byte_sel ? rd_word[15:8] : rd_word[7:0];
    case (s2_ff.op)
      DSAC_OP_SIGN_EXT:
        nxt_res = {{8{s2_ff.dest_old[7]}}, s2_ff.dest_old[7:0]};
      DSAC_OP_ZERO_EXT:
        nxt_res = {`DSAC_ZERO_BYTE, s2_ff.dest_old[7:0]};
      default:
        if (s2_ff.byte_op)
          nxt_res = {s2_ff.dest_old[15:8], rd_byte};
        else
          nxt_res = rd_word;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      RES_VALID <= 1'b0;
      RES_DATA  <= `DSAC_ZERO_WORD;
    end else begin
      RES_VALID <= s2_ff.valid;
      RES_DATA  <= nxt_res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer, limit and trap status

  logic sp_port_wr;
  assign sp_port_wr = REG_WR && (REG_ADDR == `DSAC_OFS_SP);

  // A stack operation in the same cycle as a port write wins
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      sp_ff <= `DSAC_SP_RESET;
    else if (REQ.valid && is_push(REQ.op))
      sp_ff <= sp_ff + `DSAC_WORD_STEP;
    else if (REQ.valid && (REQ.op == DSAC_OP_POP))
      sp_ff <= sp_ff - `DSAC_WORD_STEP;
    else if (sp_port_wr)
      sp_ff <= REG_WDATA & `DSAC_ALIGN_MASK;
  end

  // No reset: the limit is undefined until software writes it
  always_ff @(posedge CLK_SYS) begin
    if (REG_WR && (REG_ADDR == `DSAC_OFS_LIMIT))
      limit_ff <= REG_WDATA & `DSAC_ALIGN_MASK;
  end

  // Sticky trap flags, write one to clear; a new trap beats the clear
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      stat_ff <= `DSAC_STAT_RESET;
    else begin
      if (misalign)
        stat_ff[`DSAC_STAT_ADDR] <= 1'b1;
      else if (REG_WR && (REG_ADDR == `DSAC_OFS_STAT) &&
               REG_WDATA[`DSAC_STAT_ADDR])
        stat_ff[`DSAC_STAT_ADDR] <= 1'b0;
      if (stack_err)
        stat_ff[`DSAC_STAT_STACK] <= 1'b1;
      else if (REG_WR && (REG_ADDR == `DSAC_OFS_STAT) &&
               REG_WDATA[`DSAC_STAT_STACK])
        stat_ff[`DSAC_STAT_STACK] <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      REG_RDATA <= `DSAC_ZERO_WORD;
    else if (REG_RD) begin
      case (REG_ADDR)
        `DSAC_OFS_SP:    REG_RDATA <= sp_ff;
        `DSAC_OFS_LIMIT: REG_RDATA <= limit_ff & `DSAC_ALIGN_MASK;
        `DSAC_OFS_STAT:  REG_RDATA <= {14'h0000, stat_ff};
        default:         REG_RDATA <= `DSAC_ZERO_WORD;
      endcase
    end else
      REG_RDATA <= `DSAC_ZERO_WORD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  odd_store_block_a: assert property (
    REQ.valid && is_store && word_acc && ea[0] |=> !MEM_WE_LO && !MEM_WE_HI)
    else $error("misaligned word store reached memory");

  odd_word_trap_a: assert property (
    REQ.valid && is_mem(REQ.op) && word_acc && ea[0] |=> ADDR_TRAP)
    else $error("odd word access raised no address trap");

  byte_lane_a: assert property (
    REQ.valid && (REQ.op == DSAC_OP_STORE) && REQ.byte_op && !REQ.y_fetch &&
    !zero_rd |=> (MEM_WE_LO != MEM_WE_HI) && (MEM_WE_HI == $past(ea[0])))
    else $error("byte store hit the wrong lane");

  post_inc_step_a: assert property (
    REQ.valid && (REQ.mode == DSAC_MODE_POST_INC) && !is_stack |=>
    PTR_NEXT == $past(REQ.pointer) +
                ($past(word_acc) ? `DSAC_WORD_STEP : `DSAC_BYTE_STEP))
    else $error("post-increment step wrong");

  push_grows_a: assert property (
    REQ.valid && is_push(REQ.op) |=> sp_ff == $past(sp_ff) + `DSAC_WORD_STEP)
    else $error("push did not advance the stack pointer by one word");

  limit_even_a: assert property (
    REG_RD && (REG_ADDR == `DSAC_OFS_LIMIT) |=> !REG_RDATA[0])
    else $error("stack limit bit 0 read as one");

  underflow_trap_a: assert property (
    REQ.valid && (REQ.op == DSAC_OP_POP) &&
    (sp_ff < `DSAC_SFR_END + `DSAC_WORD_STEP) |=> STACK_TRAP)
    else $error("stack underflow raised no trap");

  near_region_a: assert property (
    REQ.valid && (REQ.mode == DSAC_MODE_NEAR) && !is_stack |=>
    MEM_WADDR[14:12] == 3'h0)
    else $error("near access left the near region");

  byte_keep_upper_a: assert property (
    REQ.valid && (REQ.op == DSAC_OP_LOAD) && !word_acc |=> ##2
    RES_VALID && RES_DATA[15:8] == $past(REQ.dest_old[15:8], 3))
    else $error("byte load changed the upper byte");

  call_push_high_a: assert property (
    REQ.valid && (REQ.op == DSAC_OP_PUSH_CALL) |=> MEM_WDATA[15:8] == 8'h00)
    else $error("call push left a nonzero high byte");

  zero_unimpl_a: assert property (
    REQ.valid && (REQ.op == DSAC_OP_LOAD) && zero_rd |=> ##2
    RES_VALID && (RES_DATA[7:0] == 8'h00))
    else $error("invalid address returned nonzero data");

  exc_push_status_a: assert property (
    REQ.valid && (REQ.op == DSAC_OP_PUSH_EXC) |=>
    MEM_WDATA[15:8] == $past(REQ.status_low_byte))
    else $error("exception push lost the status byte");

  limit_push_ok_a: assert property (
    REQ.valid && is_push(REQ.op) && (sp_ff == limit_ff) &&
    (sp_ff >= `DSAC_SFR_END) |=> !STACK_TRAP)
    else $error("push at the stack limit trapped");

  over_limit_a: assert property (
    REQ.valid && is_push(REQ.op) && (sp_ff > limit_ff) |=> STACK_TRAP)
    else $error("push above the stack limit raised no trap");

  sign_extend_a: assert property (
    REQ.valid && (REQ.op == DSAC_OP_SIGN_EXT) |=> ##2 RES_VALID &&
    (RES_DATA[7:0] == $past(REQ.dest_old[7:0], 3)) &&
    (RES_DATA[15:8] == {8{$past(REQ.dest_old[7], 3)}}))
    else $error("sign extension gave the wrong upper byte");

  y_word_only_a: assert property (
    REQ.valid && (REQ.op == DSAC_OP_LOAD) && REQ.y_fetch && !REQ.mac_x &&
    in_y(ea) |=> ##2 RES_VALID && (RES_DATA == $past(MEM_RDATA)))
    else $error("Y fetch did not return the whole word");

  full_direct_a: assert property (
    REQ.valid && (REQ.mode == DSAC_MODE_FULL) && !is_stack |=>
    MEM_WADDR == $past(REQ.addr_field[15:1]))
    else $error("direct address did not reach memory");

endmodule : dsac_top

// *** src/dsac_map.svh ***
// Address map, field positions, reset values and steps of the access unit
`ifndef DSAC_MAP_SVH
`define DSAC_MAP_SVH

// Register port offsets (byte addresses in data space)
`define DSAC_OFS_SP      16'h001e
`define DSAC_OFS_LIMIT   16'h0020
`define DSAC_OFS_STAT    16'h0040

// Reset values
`define DSAC_SP_RESET    16'h0800
`define DSAC_STAT_RESET  2'h0

// Trap status bit positions
`define DSAC_STAT_ADDR   0
`define DSAC_STAT_STACK  1

// Address space layout
`define DSAC_NEAR_TOP    16'h1fff
`define DSAC_SFR_END     16'h0800
`define DSAC_Y_BASE      16'h0c00
`define DSAC_Y_END       16'h1000
`define DSAC_IMPL_END    16'h1000

// Pointer steps and masks
`define DSAC_BYTE_STEP   16'h0001
`define DSAC_WORD_STEP   16'h0002
`define DSAC_ALIGN_MASK  16'hfffe
`define DSAC_ZERO_WORD   16'h0000
`define DSAC_ZERO_BYTE   8'h00

`endif

// *** src/dsac_pkg.sv ***
// Types shared by the data-space access unit and its users
package dsac_pkg;

  typedef enum logic [2:0] {
    DSAC_OP_LOAD,
    DSAC_OP_STORE,
    DSAC_OP_PUSH,
    DSAC_OP_PUSH_CALL,
    DSAC_OP_PUSH_EXC,
    DSAC_OP_POP,
    DSAC_OP_SIGN_EXT,
    DSAC_OP_ZERO_EXT
  } dsac_op_e;

  typedef enum logic [1:0] {
    DSAC_MODE_NEAR,
    DSAC_MODE_FULL,
    DSAC_MODE_IND,
    DSAC_MODE_POST_INC
  } dsac_mode_e;

  typedef struct packed {
    logic       valid;
    dsac_op_e   op;
    dsac_mode_e mode;
    logic       byte_op;
    logic       y_fetch;
    logic       mac_x;
    logic [15:0] addr_field;
    logic [15:0] pointer;
    logic [15:0] wdata;
    logic [15:0] dest_old;
    logic [7:0]  status_low_byte;
  } dsac_req_s;

  typedef struct packed {
    logic       valid;
    dsac_op_e   op;
    logic       byte_op;
    logic       byte_sel;
    logic       zero;
    logic [15:0] dest_old;
  } dsac_stage_s;

endpackage : dsac_pkg

// *** tb/dsac_mem_model.sv ***
// Behavioural word-wide data memory on the far side of the access unit
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module dsac_mem_model (
  // Clock
  input  wire logic        clk,
  // Memory port
  input  wire logic [14:0] waddr,
  input  wire logic        rd,
  input  wire logic        we_lo,
  input  wire logic        we_hi,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata
);
  logic [15:0] mem [0:32767];

  initial rdata = 16'h0000;

  // Two byte-wide halves behind one word decode
  always @(posedge clk) begin
    if (we_lo) mem[waddr][7:0] <= wdata[7:0];
    if (we_hi) mem[waddr][15:8] <= wdata[15:8];
  end

  // Word stands only in the cycle after the strobe; junk otherwise so a
  // late sample cannot pass by luck
  always @(posedge clk) begin
    if (rd) rdata <= mem[waddr];
    else rdata <= ~rdata;
  end
endmodule : dsac_mem_model

// *** tb/dsac_top_tb.sv ***
// Self-checking bench for the data-space access unit
`timescale 1ns/100ps
`include "dsac_map.svh"
//////////////////////////////////////////////////////////////////////////////
module dsac_top_tb import dsac_pkg::*;;
  typedef struct packed {
    dsac_req_s   q;
    logic [5:0]  f;
    logic [14:0] a;
    logic [15:0] d;
  } dsac_row_s;

  localparam dsac_op_e ld = DSAC_OP_LOAD, st = DSAC_OP_STORE,
    ps = DSAC_OP_PUSH, pc = DSAC_OP_PUSH_CALL, pe = DSAC_OP_PUSH_EXC,
    pp = DSAC_OP_POP, sx = DSAC_OP_SIGN_EXT, zx = DSAC_OP_ZERO_EXT;
  localparam dsac_mode_e near = DSAC_MODE_NEAR, full = DSAC_MODE_FULL,
    ind = DSAC_MODE_IND, inc = DSAC_MODE_POST_INC;

  logic        clk_sys, reset_n, reg_wr, reg_rd;
  dsac_req_s   req;
  logic [14:0] mem_waddr;
  logic        mem_rd, mem_we_lo, mem_we_hi, res_valid, addr_trap, stack_trap;
  logic [15:0] mem_wdata, mem_rdata, res_data, ptr_next, eptr;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  int          errors, n_compared;
  dsac_row_s   rows[$];
  dsac_row_s   w;

  dsac_top dsac_top_i (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .REQ(req),
    .MEM_WADDR(mem_waddr), .MEM_RD(mem_rd), .MEM_WE_LO(mem_we_lo),
    .MEM_WE_HI(mem_we_hi), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
    .RES_VALID(res_valid), .RES_DATA(res_data), .PTR_NEXT(ptr_next),
    .ADDR_TRAP(addr_trap), .STACK_TRAP(stack_trap), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata)
  );

  dsac_mem_model dsac_mem_model_i (
    .clk(clk_sys), .waddr(mem_waddr), .rd(mem_rd), .we_lo(mem_we_lo),
    .we_hi(mem_we_hi), .wdata(mem_wdata), .rdata(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  function automatic dsac_req_s rq(dsac_op_e op, dsac_mode_e m, bit [2:0] b,
                                   logic [15:0] p, logic [15:0] v);
    rq = '{valid: 1'b1, op: op, mode: m, byte_op: b[0], y_fetch: b[1],
           mac_x: b[2], addr_field: p, pointer: p, wdata: v, dest_old: v,
           status_low_byte: 8'h5a};
  endfunction : rq

  function automatic void row(dsac_req_s q, logic [5:0] f, logic [14:0] a,
                              logic [15:0] d);
    rows.push_back('{q, f, a, d});
  endfunction : row

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk

  task automatic chk_idle();
    chk("idle strobes", '0,
        {10'h0, mem_rd, mem_we_lo, mem_we_hi, res_valid, addr_trap,
         stack_trap});
    chk("idle data", '0, res_data | ptr_next | mem_wdata | reg_rdata);
    chk("idle address", '0, {1'b0, mem_waddr});
  endtask : chk_idle

  task automatic reg_put(logic [15:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_put

  task automatic reg_get(logic [15:0] a, logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("register", e, reg_rdata);
  endtask : reg_get

  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Whole run needs about 140 cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end

  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    req = '0;
    errors = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_idle();
    @(posedge clk_sys);
    reset_n <= 1'b1;
    reg_get(`DSAC_OFS_SP, `DSAC_SP_RESET);
    reg_get(`DSAC_OFS_STAT, '0);
    // Limit 0x0802 once bit 0 is dropped; no stack read follows at once
    reg_put(`DSAC_OFS_LIMIT, 16'h0803);
    row(rq(st, full, 0, 16'h0900, 16'h1234), 6'h18, 15'h480, 16'h1234);
    row(rq(st, full, 0, 16'h0902, 16'h5678), 6'h18, 15'h481, 16'h5678);
    row(rq(st, full, 1, 16'h0903, 16'hcdcd), 6'h10, 15'h481, 16'hcdcd);
    row(rq(st, full, 0, 16'h07fe, 16'h0a0a), 6'h18, 15'h3ff, 16'h0a0a);
    row(rq(ld, full, 1, 16'h0901, 16'hab00), 6'h24, 15'h480, 16'hab12);
    row(rq(ld, ind, 0, 16'h0902, '0), 6'h24, 15'h481, 16'hcd78);
    row(rq(ld, inc, 1, 16'h0900, 16'hff00), 6'h24, 15'h480, 16'hff34);
    row(rq(ld, inc, 0, 16'h0902, '0), 6'h24, 15'h481, 16'hcd78);
    row(rq(st, full, 0, 16'h0905, 16'h9999), 6'h01, '0, '0);
    row(rq(ld, full, 0, 16'h0903, '0), 6'h25, 15'h481, 16'hcd78);
    row(rq(sx, near, 0, '0, 16'h0080), 6'h04, '0, 16'hff80);
    row(rq(zx, near, 0, '0, 16'h12f0), 6'h04, '0, 16'h00f0);
    row(rq(ld, near, 0, 16'he900, '0), 6'h24, 15'h480, 16'h1234);
    row(rq(ld, full, 0, 16'h2000, '0), 6'h04, '0, '0);
    row(rq(ld, ind, 2, 16'h0900, '0), 6'h04, '0, '0);
    row(rq(st, full, 0, 16'h0c00, 16'h4321), 6'h18, 15'h600, 16'h4321);
    row(rq(ld, ind, 3, 16'h0c00, 16'hff00), 6'h24, 15'h600, 16'h4321);
    row(rq(ld, ind, 4, 16'h0c00, '0), 6'h04, '0, '0);
    row(rq(ps, near, 0, '0, 16'hbeef), 6'h18, 15'h400, 16'hbeef);
    row(rq(pc, near, 0, '0, 16'h12ab), 6'h18, 15'h401, 16'h00ab);
    row(rq(pe, near, 0, '0, 16'h3377), 6'h1a, 15'h402, 16'h5a77);
    row(rq(pp, near, 0, '0, '0), 6'h26, 15'h402, 16'h5a77);
    row(rq(pp, near, 0, '0, '0), 6'h24, 15'h401, 16'h00ab);
    row(rq(pp, near, 0, '0, '0), 6'h24, 15'h400, 16'hbeef);
    row(rq(pp, near, 0, '0, '0), 6'h26, 15'h3ff, 16'h0a0a);
    foreach (rows[i]) begin
      w = rows[i];
      eptr = w.q.pointer;
      if (w.q.mode == inc) begin
        eptr = eptr + (w.q.byte_op ? 16'h0001 : 16'h0002);
      end
      @(posedge clk_sys);
      req <= w.q;
      @(posedge clk_sys);
      req.valid <= 1'b0;
      @(negedge clk_sys);
      chk("strobes", {10'h0, w.f[5:3], 1'b0, w.f[1:0]},
          {10'h0, mem_rd, mem_we_hi, mem_we_lo, res_valid, stack_trap,
           addr_trap});
      chk("pointer", eptr, ptr_next);
      if (w.f[5:3] != 3'h0) begin
        chk("address", {1'b0, w.a}, {1'b0, mem_waddr});
      end
      if (w.f[4:3] != 2'h0) begin
        chk("write data", w.d, mem_wdata);
      end
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("result valid", {15'h0, w.f[2]}, {15'h0, res_valid});
      if (w.f[2]) chk("result", w.d, res_data);
    end
    reg_get(`DSAC_OFS_LIMIT, 16'h0802);
    reg_get(`DSAC_OFS_SP, 16'h07fe);
    reg_get(`DSAC_OFS_STAT, 16'h0003);
    reg_put(`DSAC_OFS_STAT, 16'h0001);
    reg_get(`DSAC_OFS_STAT, 16'h0002);
    reg_get(16'h0100, '0);
    // Pointer written over the port keeps word alignment
    reg_put(`DSAC_OFS_SP, 16'h0a01);
    reg_get(`DSAC_OFS_SP, 16'h0a00);
    // Second reset in mid-run
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(negedge clk_sys);
    chk_idle();
    @(posedge clk_sys);
    reset_n <= 1'b1;
    reg_get(`DSAC_OFS_SP, `DSAC_SP_RESET);
    reg_get(`DSAC_OFS_STAT, '0);
    // The limit has no reset, so it survives the second reset
    reg_get(`DSAC_OFS_LIMIT, 16'h0802);
    end_of_test();
  end
endmodule : dsac_top_tb
